//--- shared/per_pkg.sv
// What this block does
// - version query: opcode 0xb, length 0x1
// - version byte: major upper, revision lower nibble
// - version reply: pass header, length 0x0002
// - exactly one reply per command
// - outcome: 1 pass, 2 fail, 3 unknown
// - header: outcome, echoed command, query/error byte
// - failure: fail opcode plus reason code
// - unknown opcode gives not-recognised reply
// - echo processed command opcode in header
// - one command at a time
// - queries always pass with result byte
// - blank check: 0x0f not blank, 0xf0 blank
// - non-query success gives error byte zero
// - program verify failure gives error byte 1
// - other errors give error byte 2
// - length counts words, headers included, default 2
// - data read length is n plus 2
// - program read length from packed size
// - two program words pack into three
package per_pkg;
  // ---------------------------------------------
  // command opcodes
  // ---------------------------------------------
  localparam logic [3:0] CMD_DATA_READ = 4'h1;
  localparam logic [3:0] CMD_PROGRAM_READ = 4'h2;
  localparam logic [3:0] CMD_DATA_ROW_PROGRAM = 4'h4;
  localparam logic [3:0] CMD_PROGRAM_ROW = 4'h5;
  localparam logic [3:0] CMD_CONFIG_PROGRAM = 4'h6;
  localparam logic [3:0] CMD_ERASE_BULK = 4'h7;
  localparam logic [3:0] CMD_ERASE_DATA = 4'h8;
  localparam logic [3:0] CMD_ERASE_PROG = 4'h9;
  localparam logic [3:0] CMD_BLANK_CHECK_QUERY = 4'ha;
  localparam logic [3:0] CMD_VERSION_QUERY = 4'hb;
  localparam logic [11:0] VERSION_QUERY_LEN = 12'h001;
  // ---------------------------------------------
  // response fields
  // ---------------------------------------------
  localparam logic [3:0] RSP_PASS = 4'h1;
  localparam logic [3:0] RSP_FAIL = 4'h2;
  localparam logic [3:0] RSP_NACK = 4'h3;
  localparam int RSP_OP_MSB = 15;
  localparam int RSP_OP_LSB = 12;
  localparam int RSP_CMD_LSB = 8;
  localparam logic [7:0] QE_NO_ERROR = 8'h00;
  localparam logic [7:0] QE_VERIFY_FAIL = 8'h01;
  localparam logic [7:0] QE_OTHER_ERROR = 8'h02;
  localparam logic [7:0] QE_NOT_BLANK = 8'h0f;
  localparam logic [7:0] QE_BLANK = 8'hf0;
  localparam logic [15:0] HEADER_WORDS = 16'h0002;
  localparam int FIFO_DEPTH = 16;
endpackage

//--- src/per_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module per_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;
  // ---------------------------------------------
  // handshakes
  // ---------------------------------------------
  assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign do_wr = in_valid_in & in_ready_out;
  assign do_rd = out_valid_out & out_ready_in;
  assign out_data_out = mem_reg[rd_ptr_reg];
  always_ff @(posedge mclk_in) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

//--- src/per_packer.sv
`timescale 1ns/1ns
`default_nettype none
// packs pairs of 24-bit words into three 16-bit words
module per_packer (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic word_valid_in,
  output logic word_ready_out,
  input wire logic [23:0] word_in,
  input wire logic last_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [15:0] out_data_out
);
  logic [23:0] first_reg;
  logic [7:0] second_msb_reg;
  logic [1:0] phase_reg;
  logic [15:0] data_reg;
  logic valid_reg;
  logic take;
  logic free;
  // phase 0 empty, 1 holds first word, 2 owes the msb pair, 3 owes a zero pad
  // a lone last word gets a zero partner so every pair costs three words
  assign free = !valid_reg || out_ready_in;
  assign word_ready_out = free && !phase_reg[1];
  assign take = word_valid_in && word_ready_out;
  assign out_valid_out = valid_reg;
  assign out_data_out = data_reg;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || start_in) begin
      phase_reg <= 2'h0;
      valid_reg <= 1'b0;
      data_reg <= 16'h0000;
      first_reg <= 24'h000000;
      second_msb_reg <= 8'h00;
    end else begin
      if (valid_reg && out_ready_in) begin
        valid_reg <= 1'b0;
      end
      if (phase_reg == 2'h2 && free) begin
        data_reg <= {first_reg[23:16], second_msb_reg};
        valid_reg <= 1'b1;
        phase_reg <= 2'h0;
      end else if (phase_reg == 2'h3 && free) begin
        data_reg <= 16'h0000;
        valid_reg <= 1'b1;
        second_msb_reg <= 8'h00;
        phase_reg <= 2'h2;
      end else if (take && phase_reg == 2'h0) begin
        data_reg <= word_in[15:0];
        valid_reg <= 1'b1;
        first_reg <= word_in;
        phase_reg <= last_in ? 2'h3 : 2'h1;
      end else if (take) begin
        data_reg <= word_in[15:0];
        valid_reg <= 1'b1;
        second_msb_reg <= word_in[23:16];
        phase_reg <= 2'h2;
      end
    end
  end
endmodule
`default_nettype wire

//--- src/per_resp_gen.sv
`timescale 1ns/1ns
`default_nettype none
module per_resp_gen #(
  parameter logic [3:0] EXEC_MAJOR = 4'h1,
  parameter logic [3:0] EXEC_MINOR = 4'h0
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // command side
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [15:0] cmd_word_in,
  input wire logic [15:0] cmd_count_in,
  // outcome of the memory operation
  input wire logic op_done_in,
  input wire logic op_error_in,
  input wire logic op_verify_fail_in,
  input wire logic blank_in,
  output logic op_start_out,
  // read data stream
  input wire logic rd_valid_in,
  output logic rd_ready_out,
  input wire logic [23:0] rd_data_in,
  // response stream
  output logic rsp_valid_out,
  input wire logic rsp_ready_in,
  output logic [15:0] rsp_data_out,
  output logic busy_out
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_HEAD,
    ST_LEN,
    ST_DATA,
    ST_DRAIN
  } per_state_t;
  per_state_t state_reg;
  logic [3:0] cmd_reg;
  logic [3:0] outcome_reg;
  logic [7:0] qe_reg;
  logic [15:0] len_reg;
  logic [15:0] n_reg;
  logic [15:0] sent_reg;
  logic [15:0] fifo_wdata;
  logic fifo_wvalid;
  logic fifo_wready;
  logic pk_valid;
  logic pk_ready;
  logic [15:0] pk_data;
  logic pk_word_ready;
  logic is_prog_read;
  logic last_word;
  logic [15:0] rd_taken_reg;
  // ---------------------------------------------
  // decode helpers
  // ---------------------------------------------
  function automatic logic known_cmd(input logic [3:0] op);
    case (op)
      per_pkg::CMD_DATA_READ, per_pkg::CMD_PROGRAM_READ,
      per_pkg::CMD_DATA_ROW_PROGRAM, per_pkg::CMD_PROGRAM_ROW,
      per_pkg::CMD_CONFIG_PROGRAM, per_pkg::CMD_ERASE_BULK,
      per_pkg::CMD_ERASE_DATA, per_pkg::CMD_ERASE_PROG,
      per_pkg::CMD_BLANK_CHECK_QUERY, per_pkg::CMD_VERSION_QUERY: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  endfunction
  function automatic logic [15:0] resp_len(input logic [3:0] op, input logic [15:0] n);
    logic [15:0] half;
    half = n[0] ? (n + 16'h0001) >> 1 : n >> 1;
    if (op == per_pkg::CMD_DATA_READ) begin
      resp_len = n + per_pkg::HEADER_WORDS;
    end else if (op == per_pkg::CMD_PROGRAM_READ) begin
      resp_len = 16'(half * 16'h0003) + per_pkg::HEADER_WORDS;
    end else begin
      resp_len = per_pkg::HEADER_WORDS;
    end
  endfunction
  // ---------------------------------------------
  // command acceptance and outcome
  // ---------------------------------------------
  assign cmd_ready_out = (state_reg == ST_IDLE);
  assign busy_out = (state_reg != ST_IDLE);
  assign is_prog_read = (cmd_reg == per_pkg::CMD_PROGRAM_READ);
  assign last_word = (rd_taken_reg + 16'h0001 == n_reg);
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 4'h0;
      outcome_reg <= per_pkg::RSP_PASS;
      qe_reg <= per_pkg::QE_NO_ERROR;
      len_reg <= per_pkg::HEADER_WORDS;
      n_reg <= 16'h0000;
      op_start_out <= 1'b0;
    end else begin
      op_start_out <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid_in) begin
            cmd_reg <= cmd_word_in[15:12];
            n_reg <= cmd_count_in;
            len_reg <= resp_len(cmd_word_in[15:12], cmd_count_in);
            if (!known_cmd(cmd_word_in[15:12])) begin
              outcome_reg <= per_pkg::RSP_NACK;
              qe_reg <= per_pkg::QE_NO_ERROR;
              len_reg <= per_pkg::HEADER_WORDS;
              state_reg <= ST_HEAD;
            end else if (cmd_word_in[15:12] == per_pkg::CMD_VERSION_QUERY) begin
              outcome_reg <= per_pkg::RSP_PASS;
              qe_reg <= {EXEC_MAJOR, EXEC_MINOR};
              state_reg <= ST_HEAD;
            end else begin
              op_start_out <= 1'b1;
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          // read commands answer before data so header streams first
          if (op_done_in || cmd_reg == per_pkg::CMD_DATA_READ || is_prog_read) begin
            state_reg <= ST_HEAD;
            if (cmd_reg == per_pkg::CMD_BLANK_CHECK_QUERY) begin
              outcome_reg <= per_pkg::RSP_PASS;
              qe_reg <= blank_in ? per_pkg::QE_BLANK : per_pkg::QE_NOT_BLANK;
            end else if (op_done_in && op_verify_fail_in) begin
              outcome_reg <= per_pkg::RSP_FAIL;
              qe_reg <= per_pkg::QE_VERIFY_FAIL;
            end else if (op_done_in && op_error_in) begin
              outcome_reg <= per_pkg::RSP_FAIL;
              qe_reg <= per_pkg::QE_OTHER_ERROR;
            end else begin
              outcome_reg <= per_pkg::RSP_PASS;
              qe_reg <= per_pkg::QE_NO_ERROR;
            end
          end
        end
        ST_HEAD: if (fifo_wready) state_reg <= ST_LEN;
        ST_LEN: begin
          if (fifo_wready) begin
            state_reg <= (len_reg == per_pkg::HEADER_WORDS) ? ST_DRAIN : ST_DATA;
          end
        end
        ST_DATA: begin
          if (fifo_wvalid && fifo_wready && sent_reg + 16'h0003 == len_reg) begin
            state_reg <= ST_DRAIN;
          end
        end
        ST_DRAIN: if (!rsp_valid_out) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // ---------------------------------------------
  // data word counting
  // ---------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || state_reg == ST_IDLE) begin
      sent_reg <= 16'h0000;
      rd_taken_reg <= 16'h0000;
    end else begin
      if (state_reg == ST_DATA && fifo_wvalid && fifo_wready) begin
        sent_reg <= sent_reg + 16'h0001;
      end
      if (rd_valid_in && rd_ready_out) begin
        rd_taken_reg <= rd_taken_reg + 16'h0001;
      end
    end
  end
  // ---------------------------------------------
  // word mux toward the fifo
  // ---------------------------------------------
  assign pk_ready = (state_reg == ST_DATA) && is_prog_read && fifo_wready;
  always_comb begin
    fifo_wvalid = 1'b0;
    fifo_wdata = 16'h0000;
    rd_ready_out = 1'b0;
    case (state_reg)
      ST_HEAD: begin
        fifo_wvalid = 1'b1;
        fifo_wdata = {outcome_reg, cmd_reg, qe_reg};
      end
      ST_LEN: begin
        fifo_wvalid = 1'b1;
        fifo_wdata = len_reg;
      end
      ST_DATA: begin
        if (is_prog_read) begin
          fifo_wvalid = pk_valid;
          fifo_wdata = pk_data;
          rd_ready_out = pk_word_ready && (rd_taken_reg != n_reg);
        end else begin
          fifo_wvalid = rd_valid_in;
          fifo_wdata = rd_data_in[15:0];
          rd_ready_out = fifo_wready;
        end
      end
      default: begin
        fifo_wvalid = 1'b0;
      end
    endcase
  end
  per_packer u_packer (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .start_in(state_reg == ST_IDLE),
    .word_valid_in(rd_valid_in && is_prog_read && state_reg == ST_DATA &&
                   rd_taken_reg != n_reg),
    .word_ready_out(pk_word_ready),
    .word_in(rd_data_in),
    .last_in(last_word),
    .out_valid_out(pk_valid),
    .out_ready_in(pk_ready),
    .out_data_out(pk_data)
  );
  // back-pressure from the programmer stalls word generation
  per_fifo #(
    .WIDTH(16),
    .DEPTH(per_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(fifo_wvalid),
    .in_ready_out(fifo_wready),
    .in_data_in(fifo_wdata),
    .out_valid_out(rsp_valid_out),
    .out_ready_in(rsp_ready_in),
    .out_data_out(rsp_data_out)
  );
endmodule
`default_nettype wire

//--- sim/per_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------
// memory engine stand-in
// ----------------------------
module per_engine_model (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic op_start_in,
  input wire logic err_in,
  input wire logic vfail_in,
  input wire logic blank_in,
  input wire logic slow_in,
  input wire logic [15:0] n_in,
  input wire logic rd_ready_in,
  output logic op_done_out,
  output logic op_error_out,
  output logic op_verify_fail_out,
  output logic blank_out,
  output logic rd_valid_out,
  output logic [23:0] rd_data_out
);
  logic [3:0] wait_reg;
  logic busy_reg;
  logic run_reg;
  logic [15:0] idx_reg;
  logic [23:0] word;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      op_done_out <= 1'b0;
    end else begin
      op_done_out <= busy_reg && wait_reg == 4'h0;
      if (op_start_in) begin
        busy_reg <= 1'b1;
        wait_reg <= slow_in ? 4'h6 : 4'h1;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else begin
        busy_reg <= 1'b0;
      end
    end
  end
  // junk outside the done pulse: flags count only alongside it
  assign op_error_out = op_done_out ? err_in : ~err_in;
  assign op_verify_fail_out = op_done_out ? vfail_in : ~vfail_in;
  assign blank_out = op_done_out ? blank_in : ~blank_in;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      run_reg <= 1'b0;
      idx_reg <= 16'h0000;
    end else if (op_start_in) begin
      run_reg <= 1'b1;
      idx_reg <= 16'h0000;
    end else if (rd_valid_out && rd_ready_in) begin
      idx_reg <= idx_reg + 16'h0001;
    end
  end
  // high byte differs from low half so packing slips show
  assign word = {8'ha0 + idx_reg[7:0], 16'h1000 + idx_reg};
  assign rd_valid_out = run_reg && idx_reg < n_in;
  assign rd_data_out = rd_valid_out ? word : ~word;
endmodule
`default_nettype wire

//--- sim/per_resp_gen_props.sv
`timescale 1ns/1ns
`default_nettype none
module per_resp_gen_props #(
  parameter logic [3:0] EXEC_MAJOR = 4'h1,
  parameter logic [3:0] EXEC_MINOR = 4'h0
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic [15:0] cmd_word_in,
  input wire logic op_done_in,
  input wire logic op_error_in,
  input wire logic op_verify_fail_in,
  input wire logic blank_in,
  input wire logic op_start_out,
  input wire logic rsp_valid_out,
  input wire logic rsp_ready_in,
  input wire logic [15:0] rsp_data_out,
  input wire logic busy_out
);
  logic [3:0] op_reg;
  logic blank_reg;
  logic take;
  assign take = cmd_valid_in && cmd_ready_out;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      op_reg <= 4'h0;
    end else if (take) begin
      op_reg <= cmd_word_in[15:12];
    end
  end
  always_ff @(posedge mclk_in) begin
    if (op_done_in) begin
      blank_reg <= blank_in;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------
  // checks
  // ----------------------------
  a_start_pulse: assert property (op_start_out |=> !op_start_out)
    else $error("start pulse too long");
  a_take_busy: assert property (take |=> busy_out && !cmd_ready_out)
    else $error("second command could be taken");
  a_start_known: assert property (take |=> op_start_out ==
    ($past(cmd_word_in[15:12]) inside {[4'h1:4'h2], [4'h4:4'ha]})) else $error("bad start");
  a_ver_reply: assert property (take && cmd_word_in[15:12] == 4'hb |-> ##2
    rsp_valid_out && rsp_data_out == {8'h1b, EXEC_MAJOR, EXEC_MINOR}) else $error("bad version");
  a_nack_echo: assert property (take && cmd_word_in[15:12] inside {4'h0, 4'h3, [4'hc:4'hf]}
    |-> ##2 rsp_data_out == {4'h3, $past(cmd_word_in[15:12], 2), 8'h00}) else $error("bad nack");
  a_hold_word: assert property (rsp_valid_out && !rsp_ready_in |=>
    rsp_valid_out && $stable(rsp_data_out)) else $error("word changed while stalled");
  a_pass_zero: assert property (op_done_in && !op_error_in && !op_verify_fail_in
    && op_reg inside {[4'h4:4'h9]} |-> ##[1:3] rsp_valid_out
    && rsp_data_out == {4'h1, op_reg, 8'h00}) else $error("bad pass header");
  a_fail_verify: assert property (op_done_in && op_verify_fail_in && op_reg inside {[4'h4:4'h6]}
    |-> ##[1:3] rsp_valid_out && rsp_data_out == {4'h2, op_reg, 8'h01}) else $error("bad verify");
  a_fail_other: assert property (op_done_in && op_error_in && !op_verify_fail_in
    && op_reg inside {[4'h4:4'h9]} |-> ##[1:3] rsp_valid_out
    && rsp_data_out == {4'h2, op_reg, 8'h02}) else $error("bad error code");
  a_blank_code: assert property (op_done_in && op_reg == 4'ha |-> ##[1:3] rsp_valid_out
    && rsp_data_out == (blank_reg ? 16'h1af0 : 16'h1a0f)) else $error("bad blank code");
  c_version: cover property (take && cmd_word_in[15:12] == 4'hb);
  c_fail: cover property (rsp_valid_out && rsp_data_out[15:12] == 4'h2);
  c_stall: cover property (rsp_valid_out && !rsp_ready_in ##1 rsp_valid_out);
endmodule
bind per_resp_gen per_resp_gen_props #(.EXEC_MAJOR(EXEC_MAJOR), .EXEC_MINOR(EXEC_MINOR)) u_props (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
  .cmd_ready_out(cmd_ready_out), .cmd_word_in(cmd_word_in), .op_done_in(op_done_in),
  .op_error_in(op_error_in), .op_verify_fail_in(op_verify_fail_in), .blank_in(blank_in),
  .op_start_out(op_start_out), .rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in),
  .rsp_data_out(rsp_data_out), .busy_out(busy_out));
`default_nettype wire

//--- sim/prog_exec_response_gen_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, want) begin cmp_count++; if ((got) !== (want)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (want)); end end
module prog_exec_response_gen_bench;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [15:0] cmd_word_in = 16'h0000;
  logic [15:0] cmd_count_in = 16'h0000;
  logic rsp_ready_in = 1'b0;
  logic m_err = 1'b0;
  logic m_vf = 1'b0;
  logic m_blank = 1'b0;
  logic m_slow = 1'b0;
  logic cmd_ready_out, op_done_in, op_error_in, op_verify_fail_in, blank_in, op_start_out;
  logic rd_valid_in, rd_ready_out, rsp_valid_out, busy_out;
  logic [23:0] rd_data_in;
  logic [15:0] rsp_data_out;
  logic [15:0] exp_q[$];
  int errors = 0;
  int cmp_count = 0;
  always #25 mclk_in = ~mclk_in;
  per_resp_gen dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_word_in(cmd_word_in), .cmd_count_in(cmd_count_in),
    .op_done_in(op_done_in), .op_error_in(op_error_in), .op_verify_fail_in(op_verify_fail_in),
    .blank_in(blank_in), .op_start_out(op_start_out), .rd_valid_in(rd_valid_in),
    .rd_ready_out(rd_ready_out), .rd_data_in(rd_data_in), .rsp_valid_out(rsp_valid_out),
    .rsp_ready_in(rsp_ready_in), .rsp_data_out(rsp_data_out), .busy_out(busy_out));
  per_engine_model eng (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .op_start_in(op_start_out),
    .err_in(m_err), .vfail_in(m_vf), .blank_in(m_blank), .slow_in(m_slow), .n_in(cmd_count_in),
    .rd_ready_in(rd_ready_out), .op_done_out(op_done_in), .op_error_out(op_error_in),
    .op_verify_fail_out(op_verify_fail_in), .blank_out(blank_in), .rd_valid_out(rd_valid_in),
    .rd_data_out(rd_data_in));
  task automatic results();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic give_up();
    errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    results();
  endtask
  // sends one command, drains the reply with the given stall, then expects idle
  task automatic run(input logic [15:0] word, input logic [15:0] n, input int stall);
    int t;
    cmd_valid_in <= 1'b1;
    cmd_word_in <= word;
    cmd_count_in <= n;
    t = 0;
    do begin @(posedge mclk_in); t++; end while (!cmd_ready_out && t < 50);
    if (t >= 50) give_up();
    cmd_valid_in <= 1'b0;
    repeat (stall) @(posedge mclk_in);
    rsp_ready_in <= 1'b1;
    foreach (exp_q[i]) begin
      t = 0;
      do begin @(posedge mclk_in); t++; end while (!rsp_valid_out && t < 200);
      if (t >= 200) give_up();
      `CHK(rsp_data_out, exp_q[i])
    end
    rsp_ready_in <= 1'b0;
    t = 0;
    do begin @(posedge mclk_in); t++; end while (busy_out !== 1'b0 && t < 20);
    if (t >= 20) give_up();
    `CHK(rsp_valid_out, 1'b0)
    `CHK(cmd_ready_out, 1'b1)
    exp_q.delete();
  endtask
  task automatic t_version();
    exp_q = '{16'h1b10, 16'h0002};
    run(16'hb001, 16'h0000, 0);
  endtask
  task automatic t_unknown();
    logic [3:0] ops[6] = '{4'h0, 4'h3, 4'hc, 4'hd, 4'he, 4'hf};
    foreach (ops[i]) begin
      exp_q = '{{4'h3, ops[i], 8'h00}, 16'h0002};
      run({ops[i], 12'h001}, 16'h0000, 2);
    end
  endtask
  task automatic t_blank();
    for (int b = 0; b < 2; b++) begin
      m_blank <= b[0];
      exp_q = '{b ? 16'h1af0 : 16'h1a0f, 16'h0002};
      run(16'ha001, 16'h0000, 0);
    end
  endtask
  task automatic t_pass();
    for (logic [3:0] op = 4'h4; op <= 4'h9; op++) begin
      m_slow <= op[0];
      exp_q = '{{4'h1, op, 8'h00}, 16'h0002};
      run({op, 12'h002}, 16'h0000, 1);
    end
    m_slow <= 1'b0;
  endtask
  task automatic t_fail();
    m_vf <= 1'b1;
    for (logic [3:0] op = 4'h4; op <= 4'h6; op++) begin
      exp_q = '{{4'h2, op, 8'h01}, 16'h0002};
      run({op, 12'h013}, 16'h0000, 0);
    end
    m_vf <= 1'b0;
    m_err <= 1'b1;
    exp_q = '{16'h2702, 16'h0002};
    run(16'h7002, 16'h0000, 0);
    m_err <= 1'b0;
  endtask
  // deep stall fills the buffer so the read stream must back off
  task automatic t_dread();
    exp_q = '{16'h1100, 16'h0016};
    for (int k = 0; k < 20; k++) exp_q.push_back(16'h1000 + k[15:0]);
    run(16'h1004, 16'h0014, 30);
  endtask
  task automatic t_pread();
    exp_q = '{16'h1200, 16'h0008, 16'h1000, 16'h1001, 16'ha0a1, 16'h1002, 16'h1003, 16'ha2a3};
    run(16'h2004, 16'h0004, 3);
    exp_q = '{16'h1200, 16'h0008, 16'h1000, 16'h1001, 16'ha0a1, 16'h1002, 16'h0000, 16'ha200};
    run(16'h2004, 16'h0003, 0);
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    t_version();
    t_unknown();
    t_blank();
    t_pass();
    t_fail();
    t_dread();
    t_pread();
    results();
  end
endmodule
`default_nettype wire
